/* File: hw/enc_pkg.sv */
// shared types and constants of the quadrature encoder position interface
package enc_pkg;

  // event flag bit positions
  localparam int FLG_A = 0;
  localparam int FLG_B = 1;
  localparam int FLG_N = 2;
  localparam int FLG_REF = 3;
  localparam int FLG_ERR = 4;
  localparam int FLG_WARN = 5;
  localparam int FLG_W = 6;

  // position layout: 16.16 step, 32-bit integer position plus fraction
  localparam int INT_W = 32;
  localparam int FRAC_W = 16;
  localparam int POS_W = INT_W + FRAC_W;

  // decimal fraction limits
  localparam logic [15:0] DEC_MAX = 16'h270f;
  localparam logic [16:0] DEC_BASE = 17'h02710;

  // reset values and warm-up done count
  localparam logic [POS_W-1:0] POS_RST = 48'h0;
  localparam logic [INT_W-1:0] CAP_RST = 32'h0;
  localparam logic [FLG_W-1:0] FLG_RST = 6'h0;
  localparam logic [1:0] WARM_DONE = 2'h3;

  typedef struct packed {
    logic [31:0] step_const;
    logic dec_mode;
    logic inv_a;
    logic inv_b;
    logic inv_n;
    logic n_clr_en;
    logic n_clr_once;
    logic pid_en;
    logic [31:0] warn_dist;
  } enc_cfg_s;

  typedef struct packed {
    logic [INT_W-1:0] pos;
    logic [FRAC_W-1:0] frac;
    logic [INT_W-1:0] idx_cap;
    logic [INT_W-1:0] ref_cap;
    logic [FLG_W-1:0] flags;
    logic [INT_W-1:0] pid_err;
    logic warn_irq;
  } enc_stat_s;

endpackage : enc_pkg

/* File: hw/enc_position_if.sv */
// quadrature decoder, scaled position counter, captures and drift warning
//
// Contract
// - each decoded quadrature step adds or subtracts the step constant by direction.
// - the step constant is unsigned fixed point, sixteen integer and sixteen fraction bits.
// - decimal mode: low sixteen step bits are a fraction 0..9999; software keeps range.
// - when enabled, an index event clears the position counter.
// - optional setting: only the first index event clears, later ones do not.
// - A, B and N each selectable as active low or active high.
// - current encoder position is readable.
// - events on A, B and N are recorded in readable event flags.
// - each index event captures the current encoder position.
// - each reference switch event captures the sequencer position.
// - warning request raised when encoder to sequencer distance exceeds the limit while pid_en is set.
// - encoder position goes to PID; PID error is encoder minus sequencer position.
`timescale 1ns/1ns

module enc_position_if
  import enc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // encoder and switch pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  input wire logic ref_sw,
  // configuration and sequencer position
  input wire enc_pkg::enc_cfg_s cfg,
  input wire logic [31:0] x_actual,
  input wire logic [enc_pkg::FLG_W-1:0] flag_clr,
  // status
  output enc_pkg::enc_stat_s stat
);
  import enc_pkg::*;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [1:0] warm;
    logic [1:0] ab_prev;
    logic n_prev;
    logic r_prev;
    logic n_seen;
    logic [POS_W-1:0] pos;
    logic [INT_W-1:0] idx_cap;
    logic [INT_W-1:0] ref_cap;
    logic [FLG_W-1:0] flags;
    logic [INT_W-1:0] pid_err;
    logic warn;
  } st_s;

  st_s st_reg;
  st_s st_next;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [POS_W-1:0] step_pos(input logic [POS_W-1:0] p,
                                                input logic [31:0] k,
                                                input logic up,
                                                input logic dec);
    logic [16:0] f;
    logic [31:0] i;
    f = {1'b0, p[15:0]};
    i = p[47:16];
    if (!dec) begin
      step_pos = up ? p + {16'h0, k} : p - {16'h0, k};
    end else begin
      if (up) begin
        f = f + {1'b0, k[15:0]};
        i = i + {16'h0, k[31:16]};
        if (f >= DEC_BASE) begin
          f = f - DEC_BASE;
          i = i + 32'h1;
        end
      end else begin
        i = i - {16'h0, k[31:16]};
        if (f < {1'b0, k[15:0]}) begin
          f = f + DEC_BASE - {1'b0, k[15:0]};
          i = i - 32'h1;
        end else begin
          f = f - {1'b0, k[15:0]};
        end
      end
      step_pos = {i, f[15:0]};
    end
  endfunction : step_pos

  function automatic logic [31:0] absval(input logic [31:0] v);
    absval = v[31] ? 32'h0 - v : v;
  endfunction : absval

  ////////////////////////////////////////////////////////////////////////////
  // decode of synchronised inputs

  logic a_lvl;
  logic b_lvl;
  logic n_lvl;
  logic r_lvl;
  logic armed;
  logic [1:0] chg;
  logic cnt_ev;
  logic bad_ev;
  logic up;
  logic n_ev;
  logic r_ev;
  logic clr_ok;
  logic far;

  assign a_lvl = st_reg.s2[0] ^ cfg.inv_a;
  assign b_lvl = st_reg.s2[1] ^ cfg.inv_b;
  assign n_lvl = st_reg.s2[2] ^ cfg.inv_n;
  assign r_lvl = st_reg.s2[3];
  assign armed = st_reg.warm == WARM_DONE;
  assign chg = {a_lvl, b_lvl} ^ st_reg.ab_prev;
  assign cnt_ev = armed && (^chg);
  assign bad_ev = armed && (&chg);
  // a leads b counts up
  assign up = a_lvl ^ st_reg.ab_prev[0];
  assign n_ev = armed && n_lvl && !st_reg.n_prev;
  assign r_ev = armed && r_lvl && !st_reg.r_prev;
  assign clr_ok = n_ev && cfg.n_clr_en && !(cfg.n_clr_once && st_reg.n_seen);
  assign far = cfg.pid_en && (absval(st_reg.pid_err) > cfg.warn_dist);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [FLG_W-1:0] set;
    st_next = st_reg;
    set = '0;
    st_next.s1 = {ref_sw, enc_n, enc_b, enc_a};
    st_next.s2 = st_reg.s1;
    if (!armed) begin
      st_next.warm = st_reg.warm + 2'h1;
    end
    st_next.ab_prev = {a_lvl, b_lvl};
    st_next.n_prev = n_lvl;
    st_next.r_prev = r_lvl;
    if (cnt_ev) begin
      st_next.pos = step_pos(st_reg.pos, cfg.step_const, up, cfg.dec_mode);
    end
    if (clr_ok) begin
      st_next.pos = POS_RST;
      st_next.n_seen = 1'b1;
    end
    if (n_ev) begin
      st_next.idx_cap = st_reg.pos[47:16];
    end
    if (r_ev) begin
      st_next.ref_cap = x_actual;
    end
    set[FLG_A] = armed && chg[1];
    set[FLG_B] = armed && chg[0];
    set[FLG_N] = n_ev;
    set[FLG_REF] = r_ev;
    set[FLG_ERR] = bad_ev;
    set[FLG_WARN] = far;
    // set wins over a same-cycle clear
    st_next.flags = (st_reg.flags & ~flag_clr) | set;
    st_next.pid_err = cfg.pid_en ? st_reg.pos[47:16] - x_actual : CAP_RST;
    st_next.warn = far;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign stat.pos = st_reg.pos[47:16];
  assign stat.frac = st_reg.pos[15:0];
  assign stat.idx_cap = st_reg.idx_cap;
  assign stat.ref_cap = st_reg.ref_cap;
  assign stat.flags = st_reg.flags;
  assign stat.pid_err = st_reg.pid_err;
  assign stat.warn_irq = st_reg.warn;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_step;
    cnt_ev && !clr_ok && !cfg.dec_mode;
  endsequence

  property p_step;
    s_step |=> st_reg.pos == ($past(up) ? $past(st_reg.pos) + {16'h0, $past(cfg.step_const)}
                                        : $past(st_reg.pos) - {16'h0, $past(cfg.step_const)});
  endproperty
  a_step: assert property (p_step) else $error("binary step not applied");

  property p_double;
    bad_ev && !clr_ok |=> $stable(st_reg.pos);
  endproperty
  a_double: assert property (p_double) else $error("double transition moved position");

  property p_dec_range;
    cfg.dec_mode && cfg.step_const[15:0] <= DEC_MAX && st_reg.pos[15:0] <= DEC_MAX
      |=> st_reg.pos[15:0] <= DEC_MAX;
  endproperty
  a_dec_range: assert property (p_dec_range) else $error("decimal fraction out of range");

  property p_n_clear;
    n_ev && cfg.n_clr_en && !cfg.n_clr_once |=> st_reg.pos == POS_RST;
  endproperty
  a_n_clear: assert property (p_n_clear) else $error("index did not clear position");

  property p_once;
    n_ev && cfg.n_clr_once && st_reg.n_seen && !cnt_ev && !bad_ev |=> $stable(st_reg.pos);
  endproperty
  a_once: assert property (p_once) else $error("later index cleared position");

  property p_idx_cap;
    n_ev |=> st_reg.idx_cap == $past(st_reg.pos[47:16]);
  endproperty
  a_idx_cap: assert property (p_idx_cap) else $error("index capture wrong");

  property p_ref_cap;
    r_ev |=> st_reg.ref_cap == $past(x_actual);
  endproperty
  a_ref_cap: assert property (p_ref_cap) else $error("reference capture wrong");

  property p_flag_n;
    n_ev |=> st_reg.flags[FLG_N];
  endproperty
  a_flag_n: assert property (p_flag_n) else $error("index flag not set");

  sequence s_far;
    cfg.pid_en && (absval(st_reg.pid_err) > cfg.warn_dist);
  endsequence

  property p_warn;
    s_far |=> stat.warn_irq ##0 st_reg.flags[FLG_WARN];
  endproperty
  a_warn: assert property (p_warn) else $error("deviation warning missing");

  property p_pid;
    cfg.pid_en |=> st_reg.pid_err == $past(st_reg.pos[47:16]) - $past(x_actual);
  endproperty
  a_pid: assert property (p_pid) else $error("feedback error wrong");

  property p_pid_off;
    !cfg.pid_en |=> st_reg.pid_err == CAP_RST;
  endproperty
  a_pid_off: assert property (p_pid_off) else $error("feedback error not held at zero");

  property p_no_warn;
    !cfg.pid_en |=> !stat.warn_irq;
  endproperty
  a_no_warn: assert property (p_no_warn) else $error("warning while error path off");

  // no count leaks through while the synchroniser is still filling
  property p_quiet;
    !armed |=> $stable(st_reg.pos);
  endproperty
  a_quiet: assert property (p_quiet) else $error("count before decoder armed");

  property p_flag_ab;
    cnt_ev |=> st_reg.flags[FLG_A] || st_reg.flags[FLG_B];
  endproperty
  a_flag_ab: assert property (p_flag_ab) else $error("quadrature flag not set");

  property p_flag_ref;
    r_ev |=> st_reg.flags[FLG_REF];
  endproperty
  a_flag_ref: assert property (p_flag_ref) else $error("reference flag not set");

  property p_flag_err;
    bad_ev |=> st_reg.flags[FLG_ERR];
  endproperty
  a_flag_err: assert property (p_flag_err) else $error("double transition flag not set");

  property p_flag_clr;
    flag_clr[FLG_N] && !n_ev |=> !st_reg.flags[FLG_N];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("index flag not cleared");

  property p_n_seen;
    clr_ok |=> st_reg.n_seen;
  endproperty
  a_n_seen: assert property (p_n_seen) else $error("first index not remembered");

  property p_idx_hold;
    !n_ev |=> $stable(st_reg.idx_cap);
  endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("index capture moved");

  property p_ref_hold;
    !r_ev |=> $stable(st_reg.ref_cap);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference capture moved");

  sequence s_dec_up;
    cnt_ev && !clr_ok && cfg.dec_mode && up;
  endsequence

  sequence s_dec_dn;
    cnt_ev && !clr_ok && cfg.dec_mode && !up;
  endsequence

  // integer part moves by the step's integer part, plus at most one carry
  property p_dec_up;
    s_dec_up |=> st_reg.pos[47:16] - $past(st_reg.pos[47:16])
      - {16'h0, $past(cfg.step_const[31:16])} <= 32'h1;
  endproperty
  a_dec_up: assert property (p_dec_up) else $error("decimal carry wrong");

  property p_dec_dn;
    s_dec_dn |=> $past(st_reg.pos[47:16]) - st_reg.pos[47:16]
      - {16'h0, $past(cfg.step_const[31:16])} <= 32'h1;
  endproperty
  a_dec_dn: assert property (p_dec_dn) else $error("decimal borrow wrong");

endmodule : enc_position_if

/* File: tb/quad_enc_model.sv */
// incremental quadrature encoder model with index pin
`timescale 1ns/1ns

module quad_enc_model (
  // clock
  input wire logic clk,
  // requests from the bench
  input wire logic mv,
  input wire logic dir,
  input wire logic jump,
  input wire logic idx,
  // raw encoder pins
  output logic a,
  output logic b,
  output logic n
);
  logic [1:0] ph_reg = 2'h0;

  // jump skips one state so both pins flip together
  always_ff @(posedge clk) begin
    if (mv) ph_reg <= ph_reg + (jump ? 2'h2 : (dir ? 2'h1 : 2'h3));
  end

  // gray order 00, 10, 11, 01: a leads b going up
  assign a = ph_reg[0] ^ ph_reg[1];
  assign b = ph_reg[1];
  assign n = idx;
endmodule : quad_enc_model

/* File: tb/abn_encoder_position_interface_tb.sv */
// self-checking bench of the quadrature encoder position interface
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module abn_encoder_position_interface_tb;
  import enc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ref_sw = 1'b0;
  logic mv = 1'b0;
  logic dir = 1'b0;
  logic jump = 1'b0;
  logic idx = 1'b0;
  logic a;
  logic b;
  logic n;
  enc_cfg_s cfg = '0;
  logic [31:0] x_actual = 32'h0;
  logic [FLG_W-1:0] flag_clr = '0;
  enc_stat_s stat;
  logic [47:0] exp_pos;
  int err_total = 0;
  int n_tests = 0;

  initial begin
    forever #4 clk = ~clk;
  end

  quad_enc_model enc (.clk(clk), .mv(mv), .dir(dir), .jump(jump), .idx(idx), .a(a), .b(b),
    .n(n));
  enc_position_if uut (.clk(clk), .rst(rst), .enc_a(a ^ cfg.inv_a), .enc_b(b ^ cfg.inv_b),
    .enc_n(n ^ cfg.inv_n), .ref_sw(ref_sw), .cfg(cfg), .x_actual(x_actual),
    .flag_clr(flag_clr), .stat(stat));

  ////////////////////////////////////////
  // expected position after one count
  function automatic logic [47:0] nxt(input logic [47:0] p, input logic up);
    logic [31:0] i;
    logic [16:0] f;
    if (!cfg.dec_mode) return up ? p + {16'h0, cfg.step_const} : p - {16'h0, cfg.step_const};
    i = up ? p[47:16] + cfg.step_const[31:16] : p[47:16] - cfg.step_const[31:16];
    f = up ? {1'b0, p[15:0]} + cfg.step_const[15:0] : {1'b0, p[15:0]} - cfg.step_const[15:0];
    if (f[16]) begin
      f = f + DEC_BASE;
      i = i - 32'h1;
    end else if (f >= DEC_BASE) begin
      f = f - DEC_BASE;
      i = i + 32'h1;
    end
    return {i, f[15:0]};
  endfunction : nxt

  task automatic clks(input int k);
    repeat (k) @(posedge clk);
  endtask : clks

  task automatic step(input logic d, input logic j);
    @(posedge clk);
    mv <= 1'b1;
    dir <= d;
    jump <= j;
    @(posedge clk);
    mv <= 1'b0;
    clks(6);
    if (!j) exp_pos = nxt(exp_pos, d);
    `CHK("pos", exp_pos, {stat.pos, stat.frac})
  endtask : step

  task automatic index(input logic clr);
    logic [31:0] old;
    old = exp_pos[47:16];
    @(posedge clk) idx <= 1'b1;
    clks(4);
    idx <= 1'b0;
    clks(4);
    `CHK("idx_cap", old, stat.idx_cap)
    if (clr) exp_pos = '0;
    `CHK("pos_idx", exp_pos, {stat.pos, stat.frac})
    `CHK("flag_n", 1'b1, stat.flags[FLG_N])
  endtask : index

  task automatic close_out();
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////
  // pass 0 binary, b inverted; pass 1 decimal, a and n inverted, clear-once
  initial begin
    void'($urandom(34));
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      rst <= 1'b1;
      cfg.inv_a <= p[0];
      cfg.inv_b <= ~p[0];
      cfg.inv_n <= p[0];
      cfg.dec_mode <= p[0];
      cfg.n_clr_once <= p[0];
      cfg.n_clr_en <= 1'b1;
      cfg.pid_en <= 1'b0;
      cfg.warn_dist <= 32'h64;
      cfg.step_const <= p[0] ? {16'($urandom()), 16'($urandom_range(DEC_MAX))} : $urandom();
      clks(4);
      `CHK("stat_rst", '0, stat)
      rst <= 1'b0;
      exp_pos = '0;
      clks(4);
      repeat (12) step(1'($urandom_range(1)), 1'b0);
      repeat (2) step(1'b1, 1'b0);
      `CHK("flag_a", 1'b1, stat.flags[FLG_A])
      `CHK("flag_b", 1'b1, stat.flags[FLG_B])
      index(1'b1);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b0);
      index(p == 0);
      step(1'b1, 1'b1);
      `CHK("flag_err", 1'b1, stat.flags[FLG_ERR])
      @(posedge clk) flag_clr <= '1;
      @(posedge clk) flag_clr <= '0;
      clks(1);
      `CHK("flags_clr", FLG_RST, stat.flags)
      x_actual <= $urandom();
      ref_sw <= 1'b1;
      clks(4);
      ref_sw <= 1'b0;
      clks(2);
      `CHK("ref_cap", x_actual, stat.ref_cap)
      `CHK("flag_ref", 1'b1, stat.flags[FLG_REF])
      `CHK("warn_off", 1'b0, stat.warn_irq)
      cfg.pid_en <= 1'b1;
      x_actual <= exp_pos[47:16] - 32'h65;
      clks(4);
      `CHK("warn_on", 1'b1, stat.warn_irq)
      `CHK("flag_warn", 1'b1, stat.flags[FLG_WARN])
      x_actual <= exp_pos[47:16] - 32'h64;
      clks(4);
      `CHK("warn_edge", 1'b0, stat.warn_irq)
      `CHK("pid_err", 32'h64, stat.pid_err)
      x_actual <= exp_pos[47:16] + 32'h64;
      clks(4);
      `CHK("warn_neg", 1'b0, stat.warn_irq)
      `CHK("pid_neg", 32'hffffff9c, stat.pid_err)
      x_actual <= exp_pos[47:16] + 32'h65;
      clks(4);
      `CHK("warn_neg_on", 1'b1, stat.warn_irq)
    end
    close_out();
  end
endmodule : abn_encoder_position_interface_tb
